// ---- hdl/chip_config_consts.svh ----
// Address map, reset values and timing constants of the configuration bank.
`ifndef CHIP_CONFIG_CONSTS_SVH
`define CHIP_CONFIG_CONSTS_SVH

// Register byte addresses.
`define ADDR_ROLE_SELECT 8'hb1
`define ADDR_UNLOCK_KEY 8'hb3
`define ADDR_CLK_PORT 8'hb5
`define ADDR_OP_CONFIG 8'hb7

// Key that opens the protected fields.
`define UNLOCK_KEY_VALUE 8'h56

// Reset values.
`define RST_UNLOCK_KEY 8'h56
`define RST_CLK_PORT 8'h41
`define RST_ROLE_SELECT 1'h0
`define RST_OP_CTRL 5'h00
`define RST_RDATA 8'h00
`define RST_IRQ_PIN 1'h1
`define RST_IRQ_OE 1'h1
`define RST_DMA_REQ 2'h3
`define RST_DMA_ACCESS 2'h0
`define RST_SETTLE 4'h0

// Bits of the clock and port register that never need the key.
`define CLK_PORT_FREE_MASK 8'hc2

// Cycles after reset release before the straps are caught.
`define STRAP_SETTLE_TIME_NS 300
`define CLK_PERIOD_NS 100
`define STRAP_SETTLE_CYCLES \
   (((`STRAP_SETTLE_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`endif

// ---- hdl/chip_config_pkg.sv ----
// Types shared by the configuration bank.
package chip_config_pkg;

   typedef struct packed {
      logic ctrl_pin_termination_off;
      logic data_pin_termination_off;
      logic [3:0] reserved;
      logic port_count_mode;
      logic clock_frequency_select;
   } clk_port_t;

   typedef struct packed {
      logic irq_polarity;
      logic irq_drive_style;
      logic dma_request_polarity;
      logic dma_ack_polarity;
      logic dma_cs_mode;
      logic host_byte_order;
      logic host_strobe_style;
      logic init_done;
   } op_config_t;

   typedef struct packed {
      logic clk_24m_sel;
      logic one_port_mode;
      logic ctrl_term_en;
      logic data_term_en;
      logic port_a_host_en;
      logic port_b_host_en;
      logic port_b_device_en;
   } chip_mode_t;

   typedef enum logic [1:0] {
      INIT_SETTLE = 2'b00,
      INIT_CAPTURE = 2'b01,
      INIT_DONE = 2'b10
   } init_state_t;

endpackage : chip_config_pkg

// ---- hdl/pin_sync2.sv ----
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/10ps
module pin_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Asynchronous input and its synchronised copy.
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule : pin_sync2

// ---- hdl/chip_config_protect_bank.sv ----
// Global configuration bank with key protection, pin polarity and DMA qualification.
//
// Overview of operation
// - Operating config and clock-frequency bit take writes only while key holds 56h.
// - Key, clock/port and operating config stay accessible in sleep and snooze.
// - Clock-frequency bit picks input clock: 0 is 12 MHz, 1 is 24 MHz.
// - Port-count 0: host on port A, device on port B; 1: port B only.
// - Bit 7 switches control-pin termination, bit 6 data-pin; 0 means on.
// - Interrupt output is active low with bit 7 clear, active high with it set.
// - Bit 6 clear drives both interrupt levels; set drives only the asserted level.
// - DMA request polarity follows bit 5, acknowledge polarity bit 4; 1 is high.
// - Bit 3 clear accepts DMA on acknowledge alone; set also needs chip select.
// - Read-only bit 2 reports host byte order: 0 big-endian, 1 little-endian.
// - Read-only bit 1 reports write style: 0 separate strobes, 1 byte enables.
// - Read-only bit 0 reads 1 once initialisation has completed.
// - In one-port mode the role bit selects device (0) or host (1) function.
`timescale 1ns/10ps
`include "chip_config_consts.svh"
module chip_config_protect_bank (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Strap pins for the host bus style.
   input wire logic endian_strap_i,
   input wire logic strobe_style_strap_i,
   // Operating mode towards the rest of the chip.
   output chip_config_pkg::chip_mode_t mode_o,
   // Interrupt pin.
   input wire logic irq_req_i,
   output logic irq_out_pin_o,
   output logic irq_out_pin_oe_o,
   // DMA pins.
   input wire logic [1:0] dma_req_i,
   output logic [1:0] dma_request_pins_o,
   input wire logic [1:0] dma_ack_pins_i,
   input wire logic chip_select_pin_b_i,
   output logic [1:0] dma_access_o
);

   // Register state.
   logic [7:0] key_reg;
   chip_config_pkg::clk_port_t clk_port_reg;
   logic [4:0] op_ctrl_reg;
   logic role_select_bit_reg;
   logic host_byte_order_reg;
   logic host_strobe_style_reg;
   logic init_done_reg;
   logic [7:0] rdata_reg;
   chip_config_pkg::init_state_t init_state_reg;
   chip_config_pkg::init_state_t init_state_next;
   logic [3:0] settle_reg;

   // Pin outputs.
   logic irq_pin_reg;
   logic irq_oe_reg;
   logic [1:0] dma_req_reg;
   logic [1:0] dma_access_reg;

   // Synchronised pins. Acknowledge and chip select enter inverted so that the
   // cleared synchroniser reads as idle pins; otherwise the default active-low
   // polarity would show a false acknowledge for two cycles after reset.
   logic [1:0] strap_sync;
   logic [1:0] ack_low_sync;
   logic cs_active_sync;

   pin_sync2 #(
      .WIDTH(5)
   ) pin_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .async_i({strobe_style_strap_i, endian_strap_i, ~dma_ack_pins_i,
                ~chip_select_pin_b_i}),
      .sync_o({strap_sync, ack_low_sync, cs_active_sync})
   );

   // Address decode. No power-state term gates it, so every register stays
   // reachable in sleep and snooze.
   wire hit_key = (addr_i == `ADDR_UNLOCK_KEY);
   wire hit_clk = (addr_i == `ADDR_CLK_PORT);
   wire hit_op = (addr_i == `ADDR_OP_CONFIG);
   wire hit_role = (addr_i == `ADDR_ROLE_SELECT);
   wire unlocked = (key_reg == `UNLOCK_KEY_VALUE);

   wire wr_key = wr_i && hit_key;
   wire wr_clk = wr_i && hit_clk;
   wire wr_op = wr_i && hit_op && unlocked;
   wire wr_role = wr_i && hit_role;

   // The frequency bit is kept back while locked; bits 7, 6 and 1 always land, reserved bits 5:2 never do.
   wire [7:0] clk_free_mask = `CLK_PORT_FREE_MASK;
   wire [7:0] clk_wmask = unlocked ? (clk_free_mask | 8'h01) : clk_free_mask;
   wire [7:0] clk_port_next = (wdata_i & clk_wmask) | (clk_port_reg & ~clk_wmask);

   chip_config_pkg::op_config_t op_view;
   assign op_view = {op_ctrl_reg, host_byte_order_reg, host_strobe_style_reg,
                     init_done_reg};

   wire [7:0] rd_mux = hit_key ? key_reg :
                       hit_clk ? clk_port_reg :
                       hit_op ? op_view :
                       hit_role ? {7'h00, role_select_bit_reg} :
                       `RST_RDATA;
   wire [7:0] rdata_next = rd_i ? rd_mux : `RST_RDATA;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         key_reg <= `RST_UNLOCK_KEY;
         clk_port_reg <= `RST_CLK_PORT;
         op_ctrl_reg <= `RST_OP_CTRL;
         role_select_bit_reg <= `RST_ROLE_SELECT;
         rdata_reg <= `RST_RDATA;
      end else begin
         if (wr_key) begin
            key_reg <= wdata_i;
         end
         if (wr_clk) begin
            clk_port_reg <= clk_port_next;
         end
         if (wr_op) begin
            op_ctrl_reg <= wdata_i[7:3];
         end
         if (wr_role) begin
            role_select_bit_reg <= wdata_i[0];
         end
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;

   // Straps are caught after reset once the synchroniser has filled; the
   // done flag rises with them so software never reads a half-valid view.
   wire settle_end = (settle_reg == 4'(`STRAP_SETTLE_CYCLES));

   always_comb begin
      init_state_next = init_state_reg;
      case (init_state_reg)
         chip_config_pkg::INIT_SETTLE: begin
            if (settle_end) begin
               init_state_next = chip_config_pkg::INIT_CAPTURE;
            end
         end
         chip_config_pkg::INIT_CAPTURE: begin
            init_state_next = chip_config_pkg::INIT_DONE;
         end
         chip_config_pkg::INIT_DONE: begin
            init_state_next = chip_config_pkg::INIT_DONE;
         end
         default: begin
            init_state_next = chip_config_pkg::INIT_SETTLE;
         end
      endcase
   end

   wire capture = (init_state_reg == chip_config_pkg::INIT_CAPTURE);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         init_state_reg <= chip_config_pkg::INIT_SETTLE;
         settle_reg <= `RST_SETTLE;
         host_byte_order_reg <= 1'h0;
         host_strobe_style_reg <= 1'h0;
         init_done_reg <= 1'h0;
      end else begin
         init_state_reg <= init_state_next;
         if (!settle_end) begin
            settle_reg <= settle_reg + 4'h1;
         end
         if (capture) begin
            host_byte_order_reg <= strap_sync[0];
            host_strobe_style_reg <= strap_sync[1];
            init_done_reg <= 1'h1;
         end
      end
   end

   // Mode outputs.
   wire one_port = clk_port_reg.port_count_mode;
   assign mode_o.clk_24m_sel = clk_port_reg.clock_frequency_select;
   assign mode_o.one_port_mode = one_port;
   assign mode_o.ctrl_term_en = ~clk_port_reg.ctrl_pin_termination_off;
   assign mode_o.data_term_en = ~clk_port_reg.data_pin_termination_off;
   assign mode_o.port_a_host_en = ~one_port;
   assign mode_o.port_b_host_en = one_port && role_select_bit_reg;
   assign mode_o.port_b_device_en = ~one_port || ~role_select_bit_reg;

   // Interrupt pin: the active level follows the polarity bit, and in the
   // float style the pin is released when idle so lines can be wire-ORed.
   wire irq_pol = op_ctrl_reg[4];
   wire irq_float = op_ctrl_reg[3];
   wire irq_pin_next = irq_req_i ? irq_pol : ~irq_pol;
   wire irq_oe_next = ~irq_float || irq_req_i;

   // DMA pins.
   wire dreq_pol = op_ctrl_reg[2];
   wire dack_pol = op_ctrl_reg[1];
   wire cs_mode = op_ctrl_reg[0];
   wire [1:0] dma_req_next = dreq_pol ? dma_req_i : ~dma_req_i;
   wire [1:0] ack_active = dack_pol ? ~ack_low_sync : ack_low_sync;
   wire cs_qual = cs_mode ? cs_active_sync : 1'b1;
   wire [1:0] dma_access_next = ack_active & {2{cs_qual}};

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_pin_reg <= `RST_IRQ_PIN;
         irq_oe_reg <= `RST_IRQ_OE;
         dma_req_reg <= `RST_DMA_REQ;
         dma_access_reg <= `RST_DMA_ACCESS;
      end else begin
         irq_pin_reg <= irq_pin_next;
         irq_oe_reg <= irq_oe_next;
         dma_req_reg <= dma_req_next;
         dma_access_reg <= dma_access_next;
      end
   end

   assign irq_out_pin_o = irq_pin_reg;
   assign irq_out_pin_oe_o = irq_oe_reg;
   assign dma_request_pins_o = dma_req_reg;
   assign dma_access_o = dma_access_reg;

   // Checks.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence op_wr_locked_s;
      wr_i && hit_op && !unlocked;
   endsequence

   sequence op_wr_open_s;
      wr_i && hit_op && unlocked;
   endsequence

   sequence key_read_s;
      rd_i && hit_key;
   endsequence

   sequence reset_release_s;
      $rose(rst_b_i);
   endsequence

   sequence init_wait_s;
      !init_done_reg [*5];
   endsequence

   sequence clk_wr_open_s;
      wr_i && hit_clk && unlocked;
   endsequence

   op_write_open_a: assert property (
      op_wr_open_s |=> op_ctrl_reg == $past(wdata_i[7:3]))
      else $error("Unlocked config write was not stored.");

   op_write_locked_a: assert property (
      op_wr_locked_s |=> $stable(op_ctrl_reg))
      else $error("Locked config write changed the register.");

   clk_sel_lock_a: assert property (
      wr_i && hit_clk && !unlocked |=> $stable(mode_o.clk_24m_sel))
      else $error("Locked write changed the clock select.");

   term_write_a: assert property (
      wr_i && hit_clk |=> mode_o.ctrl_term_en == !$past(wdata_i[7]) &&
                         mode_o.data_term_en == !$past(wdata_i[6]))
      else $error("Termination bits did not follow the write.");

   key_readback_a: assert property (
      key_read_s ##0 !wr_i |=> rdata_o == $past(key_reg))
      else $error("Key register read back wrong.");

   rdata_idle_a: assert property (
      !rd_i |=> rdata_o == 8'h00)
      else $error("Read data present without a read.");

   irq_level_a: assert property (
      irq_req_i && !irq_float |=> irq_out_pin_o == $past(irq_pol) && irq_out_pin_oe_o)
      else $error("Interrupt pin shows the wrong active level.");

   irq_float_a: assert property (
      !irq_req_i && irq_float |=> !irq_out_pin_oe_o)
      else $error("Interrupt pin driven while idle in float style.");

   dma_req_pol_a: assert property (
      1'b1 |=> dma_request_pins_o == ($past(dreq_pol) ? $past(dma_req_i) :
                                      ~$past(dma_req_i)))
      else $error("DMA request polarity wrong.");

   dma_cs_qual_a: assert property (
      cs_mode && !cs_active_sync |=> dma_access_o == 2'h0)
      else $error("DMA access accepted without chip select.");

   init_flag_a: assert property (
      reset_release_s |-> ##5 init_done_reg ##1 init_done_reg [*3])
      else $error("Initialisation flag not set in time.");

   port_mode_a: assert property (
      one_port |-> !mode_o.port_a_host_en &&
                   mode_o.port_b_host_en == role_select_bit_reg)
      else $error("One-port role selection wrong.");

   init_wait_a: assert property (
      reset_release_s |-> init_wait_s)
      else $error("Initialisation flag set before the straps were caught.");

   clk_sel_open_a: assert property (
      clk_wr_open_s |=> mode_o.clk_24m_sel == $past(wdata_i[0]))
      else $error("Unlocked write did not set the clock select.");

   port_two_a: assert property (
      !one_port |-> mode_o.port_a_host_en && mode_o.port_b_device_en &&
                    !mode_o.port_b_host_en)
      else $error("Two-port mode does not split host and device.");

   irq_drive_a: assert property (
      !irq_float |=> irq_out_pin_oe_o)
      else $error("Interrupt pin released in push-pull style.");

   dma_ack_pol_a: assert property (
      !cs_mode |=> dma_access_o == ($past(dack_pol) ? ~$past(ack_low_sync) :
                                    $past(ack_low_sync)))
      else $error("DMA acknowledge polarity wrong.");

   ro_bits_hold_a: assert property (
      wr_i && hit_op && init_done_reg |=> $stable({host_byte_order_reg,
                                                   host_strobe_style_reg}))
      else $error("Write changed a read-only status bit.");

   op_read_a: assert property (
      rd_i && hit_op && !wr_i |=> rdata_o[2:0] == $past({host_byte_order_reg,
                                  host_strobe_style_reg, init_done_reg}))
      else $error("Status bits read back wrong.");

   key_write_a: assert property (
      wr_i && hit_key |=> key_reg == $past(wdata_i))
      else $error("Key register did not take the write.");

endmodule : chip_config_protect_bank

// ---- testbench/host_pin_model.sv ----
// Host-side pin model: DMA acknowledge and chip select pins, interrupt line resolution.
`timescale 1ns/10ps
module host_pin_model (
   // Clock.
   input wire logic clk_i,
   // Logical requests from the bench.
   input wire logic ack_pol_i,
   input wire logic [1:0] ack_act_i,
   input wire logic cs_act_i,
   // Pins.
   output logic [1:0] dma_ack_pins_o,
   output logic chip_select_pin_b_o,
   input wire logic irq_pin_i,
   input wire logic irq_oe_i,
   output logic irq_line_o
);
   logic last_reg = 1'h0;
   assign dma_ack_pins_o = ack_pol_i ? ack_act_i : ~ack_act_i;
   assign chip_select_pin_b_o = ~cs_act_i;
   // The line has no pull resistor, so a floated pin flips every cycle rather than holding.
   assign irq_line_o = irq_oe_i ? irq_pin_i : ~last_reg;
   always @(posedge clk_i) begin
      last_reg <= irq_line_o;
   end
endmodule : host_pin_model

// ---- testbench/tb_top.sv ----
// Self-checking testbench of the configuration bank.
`timescale 1ns/10ps
`include "chip_config_consts.svh"
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [7:0] rdata;
   logic endian = 1'h0;
   logic strobe = 1'h0;
   chip_config_pkg::chip_mode_t mode;
   logic irq_req = 1'h0;
   logic irq_pin;
   logic irq_oe;
   logic irq_line;
   logic [1:0] dma_req = 2'h0;
   logic [1:0] dma_pins;
   logic [1:0] ack_pins;
   logic cs_b;
   logic [1:0] dma_access;
   logic ack_pol = 1'h0;
   logic [1:0] ack_act = 2'h0;
   logic cs_act = 1'h0;
   int mismatches = 0;
   int n_compared = 0;
   logic [31:0] seed;
   logic [7:0] d;
   logic [7:0] cp;
   logic [4:0] op;
   logic role;
   logic locked;
   logic [31:0] r;

   always #50 clk = ~clk;

   chip_config_protect_bank dut_u (
      .clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .endian_strap_i(endian), .strobe_style_strap_i(strobe), .mode_o(mode),
      .irq_req_i(irq_req), .irq_out_pin_o(irq_pin), .irq_out_pin_oe_o(irq_oe),
      .dma_req_i(dma_req), .dma_request_pins_o(dma_pins), .dma_ack_pins_i(ack_pins),
      .chip_select_pin_b_i(cs_b), .dma_access_o(dma_access));

   host_pin_model partner_u (
      .clk_i(clk), .ack_pol_i(ack_pol), .ack_act_i(ack_act), .cs_act_i(cs_act),
      .dma_ack_pins_o(ack_pins), .chip_select_pin_b_o(cs_b), .irq_pin_i(irq_pin),
      .irq_oe_i(irq_oe), .irq_line_o(irq_line));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic chip_config_pkg::chip_mode_t exp_mode(input logic [7:0] c, input logic ro);
      chip_config_pkg::chip_mode_t m;
      m.clk_24m_sel = c[0];
      m.one_port_mode = c[1];
      m.ctrl_term_en = ~c[7];
      m.data_term_en = ~c[6];
      m.port_a_host_en = ~c[1];
      m.port_b_host_en = c[1] & ro;
      m.port_b_device_en = ~c[1] | ~ro;
      return m;
   endfunction : exp_mode

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      v = rdata;
   endtask : rd_reg

   task automatic report_and_stop();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      seed = 32'h0001541e;
      r = rnd();
      endian <= r[0];
      strobe <= r[1];
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      // Pins stay idle through the release, so nothing may look acknowledged while
      // the synchronisers fill and the strap capture settles.
      for (int k = 0; k < 10; k++) begin
         @(posedge clk);
         #1;
         `CHECK(dma_access, 2'h0)
         `CHECK(dma_pins, 2'h3)
      end
      cp = 8'h41;
      op = 5'h00;
      role = 1'h0;
      rd_reg(`ADDR_UNLOCK_KEY, d);
      `CHECK(d, 8'h56)
      rd_reg(`ADDR_ROLE_SELECT, d);
      `CHECK(d, 8'h00)
      rd_reg(8'hb4, d);
      `CHECK(d, 8'h00)
      rd_reg(`ADDR_OP_CONFIG, d);
      `CHECK(d, {5'h00, endian, strobe, 1'h1})
      for (int i = 0; i < 48; i++) begin
         locked = (i % 16) >= 8;
         wr_reg(`ADDR_UNLOCK_KEY, locked ? 8'h00 : 8'h56);
         r = rnd();
         wr_reg(`ADDR_OP_CONFIG, r[7:0]);
         if (!locked) begin
            op = r[7:3];
         end
         wr_reg(`ADDR_CLK_PORT, r[15:8]);
         cp = {r[15:14], 4'h0, r[9], locked ? cp[0] : r[8]};
         wr_reg(`ADDR_ROLE_SELECT, {7'h00, r[16]});
         role = r[16];
         irq_req <= r[17];
         dma_req <= r[19:18];
         ack_act <= r[21:20];
         cs_act <= r[22];
         ack_pol <= op[1];
         repeat (5) @(posedge clk);
         rd_reg(`ADDR_UNLOCK_KEY, d);
         `CHECK(d, locked ? 8'h00 : 8'h56)
         rd_reg(`ADDR_OP_CONFIG, d);
         `CHECK(d, {op, endian, strobe, 1'h1})
         rd_reg(`ADDR_CLK_PORT, d);
         `CHECK(d, cp)
         `CHECK(mode, exp_mode(cp, role))
         `CHECK(irq_oe, op[3] ? irq_req : 1'h1)
         if (irq_oe === 1'h1) begin
            `CHECK(irq_line, irq_req ? op[4] : ~op[4])
         end
         `CHECK(dma_pins, op[2] ? dma_req : ~dma_req)
         `CHECK(dma_access, ack_act & {2{~op[0] | cs_act}})
      end
      report_and_stop();
   end
endmodule : tb_top
